// file: hdl/intr_route_map.vh
// register offsets, field positions and reset values of the interrupt router
`ifndef INTR_ROUTE_MAP_VH
`define INTR_ROUTE_MAP_VH

`define OFF_INTERRUPT_CLEAR 12'h000
`define OFF_LINE_MAP_FIRST 12'h004
`define OFF_LINE_MAP_SECOND 12'h008
`define OFF_PENDING_STATUS 12'h00C
`define OFF_MASK 12'h010
`define OFF_INTR_STATUS 12'h014
`define OFF_INTR_MASK 12'h018

// source index order, also the pending status and mask layout
`define SRC_MAILBOX0 0
`define SRC_LOCMON0 4
`define SRC_DMA_CH0 8
`define SRC_DMA_CH1 9
`define SRC_VME_LEVEL1 10
`define SRC_PCI_ERR 17
`define SRC_VME_ERR 18
`define SRC_VME_EDGE 19
`define SRC_ACK_DONE 20
`define SRC_SYS_FAIL 21
`define SRC_POWER_FAIL 22
`define NUM_SRC 23

// clear register bit positions
`define CLR_MAILBOX0 16
`define CLR_LOCMON0 20
`define CLR_DMA_CH0 24
`define CLR_DMA_CH1 25
`define CLR_PCI_ERR 13
`define CLR_VME_ERR 12
`define CLR_VME_EDGE 11
`define CLR_ACK_DONE 10
`define CLR_SYS_FAIL 9
`define CLR_POWER_FAIL 8

// map first: mailbox0 at 1:0, locmon0 at 9:8, dma0 at 17:16
`define MAP1_MAILBOX0_LSB 0
`define MAP1_LOCMON0_LSB 8
`define MAP1_DMA_CH0_LSB 16
`define MAP1_WRITE_MASK 32'h000F_FFFF
// map second: level1 at 3:2 .. level7 at 15:14, others above
`define MAP2_VME_LEVEL1_LSB 2
`define MAP2_PCI_ERR_LSB 16
`define MAP2_VME_ERR_LSB 18
`define MAP2_VME_EDGE_LSB 20
`define MAP2_ACK_DONE_LSB 22
`define MAP2_SYS_FAIL_LSB 24
`define MAP2_POWER_FAIL_LSB 26
`define MAP2_WRITE_MASK 32'h0FFF_FFFC
`define MAP_RESET 32'h0000_0000

`define NUM_LINES 4
`define EVT_BITS 2
`define EVT_SET_ERR 0
`define EVT_UNMAPPED 1
`endif

// file: hdl/sync_two_ff.v
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sync_two_ff #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// file: hdl/line_route.v
// routes pending sources onto four active-low interrupt lines
`timescale 1ns/1ps
module line_route #(
    parameter NSRC = 23
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [NSRC-1:0] pending,
    input wire [2*NSRC-1:0] line_sel,
    output reg [3:0] int_line_n
);
    wire [3:0] hit [0:NSRC];
    assign hit[0] = 4'h0;

    genvar i;
    generate
        for (i = 0; i < NSRC; i = i + 1) begin : g_src
            assign hit[i+1] = hit[i] |
                ({4{pending[i]}} & (4'h1 << line_sel[2*i+1:2*i]));
        end
    endgenerate

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_line_n <= 4'hF;
        end else begin
            int_line_n <= ~hit[NSRC];
        end
    end
endmodule

// file: hdl/intr_route.v
// interrupt clear and pci line routing block with apb register slave
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "intr_route_map.vh"
module intr_route (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire [`NUM_SRC-1:0] src_event,
    input wire [`NUM_SRC-1:0] src_async,
    output wire [3:0] int_line_n,
    output wire irq
);
    localparam NS = `NUM_SRC;

    reg [NS-1:0] pending_r;
    reg [NS-1:0] pending_nxt;
    reg [NS-1:0] src_mask_r;
    reg [31:0] map1_r;
    reg [31:0] map2_r;
    reg [`EVT_BITS-1:0] evt_status_r;
    reg [`EVT_BITS-1:0] evt_mask_r;
    reg [NS-1:0] async_prev_r;
    reg [NS-1:0] clr_vec;
    reg [2*NS-1:0] line_sel;
    reg addr_ok;
    wire [NS-1:0] async_sync;
    wire [NS-1:0] async_rise;
    wire [NS-1:0] raw_set;
    wire wr_en;
    wire rd_en;
    wire [`EVT_BITS-1:0] evt_set;
    integer k;
    integer j;

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    always @* begin
        case (paddr)
            `OFF_INTERRUPT_CLEAR,
            `OFF_LINE_MAP_FIRST,
            `OFF_LINE_MAP_SECOND,
            `OFF_PENDING_STATUS,
            `OFF_MASK,
            `OFF_INTR_STATUS,
            `OFF_INTR_MASK: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    sync_two_ff #(
        .WIDTH(NS)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(src_async),
        .sync_out(async_sync)
    );

    // rising edges of pin-level sources become events
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            async_prev_r <= {NS{1'b0}};
        end else begin
            async_prev_r <= async_sync;
        end
    end
    assign async_rise = async_sync & ~async_prev_r;
    assign raw_set = (src_event | async_rise) & src_mask_r;

    // clear command bits mapped onto source order
    always @* begin
        clr_vec = {NS{1'b0}};
        if (wr_en && paddr == `OFF_INTERRUPT_CLEAR) begin
            for (k = 0; k < 4; k = k + 1) begin
                clr_vec[`SRC_MAILBOX0+k] = pwdata[`CLR_MAILBOX0+k];
                clr_vec[`SRC_LOCMON0+k] = pwdata[`CLR_LOCMON0+k];
            end
            clr_vec[`SRC_DMA_CH0] = pwdata[`CLR_DMA_CH0];
            clr_vec[`SRC_DMA_CH1] = pwdata[`CLR_DMA_CH1];
            clr_vec[`SRC_PCI_ERR] = pwdata[`CLR_PCI_ERR];
            clr_vec[`SRC_VME_ERR] = pwdata[`CLR_VME_ERR];
            clr_vec[`SRC_VME_EDGE] = pwdata[`CLR_VME_EDGE];
            clr_vec[`SRC_ACK_DONE] = pwdata[`CLR_ACK_DONE];
            clr_vec[`SRC_SYS_FAIL] = pwdata[`CLR_SYS_FAIL];
            clr_vec[`SRC_POWER_FAIL] = pwdata[`CLR_POWER_FAIL];
        end
    end

    always @* begin
        pending_nxt = (pending_r & ~clr_vec) | raw_set;
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= {NS{1'b0}};
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // map and mask writable fields, maps and event mask reset zero, source mask reset all ones
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            map1_r <= `MAP_RESET;
            map2_r <= `MAP_RESET;
            src_mask_r <= {NS{1'b1}};
            evt_mask_r <= {`EVT_BITS{1'b0}};
        end else if (wr_en) begin
            if (paddr == `OFF_LINE_MAP_FIRST) begin
                map1_r <= pwdata & `MAP1_WRITE_MASK;
            end
            if (paddr == `OFF_LINE_MAP_SECOND) begin
                map2_r <= pwdata & `MAP2_WRITE_MASK;
            end
            if (paddr == `OFF_MASK) begin
                src_mask_r <= pwdata[NS-1:0];
            end
            if (paddr == `OFF_INTR_MASK) begin
                evt_mask_r <= pwdata[`EVT_BITS-1:0];
            end
        end
    end

    // gather per-source line select fields
    always @* begin
        line_sel = {2*NS{1'b0}};
        for (j = 0; j < 4; j = j + 1) begin
            line_sel[2*(`SRC_MAILBOX0+j) +: 2] = map1_r[`MAP1_MAILBOX0_LSB+2*j +: 2];
            line_sel[2*(`SRC_LOCMON0+j) +: 2] = map1_r[`MAP1_LOCMON0_LSB+2*j +: 2];
        end
        for (j = 0; j < 2; j = j + 1) begin
            line_sel[2*(`SRC_DMA_CH0+j) +: 2] = map1_r[`MAP1_DMA_CH0_LSB+2*j +: 2];
        end
        for (j = 0; j < 7; j = j + 1) begin
            line_sel[2*(`SRC_VME_LEVEL1+j) +: 2] = map2_r[`MAP2_VME_LEVEL1_LSB+2*j +: 2];
        end
        line_sel[2*`SRC_PCI_ERR +: 2] = map2_r[`MAP2_PCI_ERR_LSB +: 2];
        line_sel[2*`SRC_VME_ERR +: 2] = map2_r[`MAP2_VME_ERR_LSB +: 2];
        line_sel[2*`SRC_VME_EDGE +: 2] = map2_r[`MAP2_VME_EDGE_LSB +: 2];
        line_sel[2*`SRC_ACK_DONE +: 2] = map2_r[`MAP2_ACK_DONE_LSB +: 2];
        line_sel[2*`SRC_SYS_FAIL +: 2] = map2_r[`MAP2_SYS_FAIL_LSB +: 2];
        line_sel[2*`SRC_POWER_FAIL +: 2] = map2_r[`MAP2_POWER_FAIL_LSB +: 2];
    end

    line_route #(
        .NSRC(NS)
    ) u_route (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pending(pending_r),
        .line_sel(line_sel),
        .int_line_n(int_line_n)
    );

    // block events: clear hit an idle source, bad address access
    assign evt_set[`EVT_SET_ERR] = wr_en & (paddr == `OFF_INTERRUPT_CLEAR) &
        (|(clr_vec & ~pending_r));
    assign evt_set[`EVT_UNMAPPED] = psel & penable & ~addr_ok;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_status_r <= {`EVT_BITS{1'b0}};
        end else if (wr_en && paddr == `OFF_INTR_STATUS) begin
            evt_status_r <= (evt_status_r & ~pwdata[`EVT_BITS-1:0]) | evt_set;
        end else begin
            evt_status_r <= evt_status_r | evt_set;
        end
    end
    assign irq = |(evt_status_r & evt_mask_r);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFF_LINE_MAP_FIRST: begin
                    prdata <= map1_r;
                end
                `OFF_LINE_MAP_SECOND: begin
                    prdata <= map2_r;
                end
                `OFF_PENDING_STATUS: begin
                    prdata <= {{(32-NS){1'b0}}, pending_r};
                end
                `OFF_MASK: begin
                    prdata <= {{(32-NS){1'b0}}, src_mask_r};
                end
                `OFF_INTR_STATUS: begin
                    prdata <= {{(32-`EVT_BITS){1'b0}}, evt_status_r};
                end
                `OFF_INTR_MASK: begin
                    prdata <= {{(32-`EVT_BITS){1'b0}}, evt_mask_r};
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

// file: testbench/intr_route_monitor.sv
// port level assertions for the interrupt router
`timescale 1ns/1ps
`include "intr_route_map.vh"
module intr_route_monitor (
    input wire sys_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [`NUM_SRC-1:0] src_event,
    input wire [`NUM_SRC-1:0] src_async,
    input wire [3:0] int_line_n,
    input wire irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & !pwrite;
    reg [31:0] map1_r;
    reg [31:0] map2_r;
    // shadow copies of the two map registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            map1_r <= 32'h0000_0000;
            map2_r <= 32'h0000_0000;
        end else if (wr && paddr == `OFF_LINE_MAP_FIRST) begin
            map1_r <= pwdata & 32'h000F_FFFF;
        end else if (wr && paddr == `OFF_LINE_MAP_SECOND) begin
            map2_r <= pwdata & 32'h0FFF_FFFC;
        end
    end
    property p_clr_zero;
        rd && paddr == `OFF_INTERRUPT_CLEAR |-> prdata == 32'h0000_0000;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("clear register read nonzero");
    property p_map1;
        rd && paddr == `OFF_LINE_MAP_FIRST |-> prdata == map1_r;
    endproperty
    a_map1: assert property (p_map1) else $error("first map readback wrong");
    property p_map2;
        rd && paddr == `OFF_LINE_MAP_SECOND |-> prdata == map2_r;
    endproperty
    a_map2: assert property (p_map2) else $error("second map readback wrong");
    property p_hold;
        (int_line_n & ~$past(int_line_n)) != 4'h0 |-> $past(wr) || $past(wr, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("line released without a write");
    property p_bad_addr;
        acc && paddr > 12'h018 |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");
    property p_good_addr;
        acc && paddr <= 12'h018 && paddr[1:0] == 2'b00 |-> !pslverr && pready;
    endproperty
    a_good_addr: assert property (p_good_addr) else $error("mapped access refused");
    property p_rdata_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_irq_cause;
        $rose(irq) |-> $past(acc) || $past(acc, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose without access");
    c_clear: cover property (wr && paddr == `OFF_INTERRUPT_CLEAR);
    c_line: cover property (int_line_n != 4'hF);
    c_irq: cover property ($rose(irq));
endmodule
bind intr_route intr_route_monitor u_intr_route_monitor (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_event(src_event),
    .src_async(src_async), .int_line_n(int_line_n), .irq(irq));

// file: testbench/host_irq_model.sv
// host interrupt controller watching the four pci lines
`timescale 1ns/1ps
module host_irq_model (
    input wire sys_clk,
    input wire rst_n,
    input wire [3:0] int_line_n,
    output reg [3:0] asserted
);
    // a line counts as raised while driven low
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            asserted <= 4'h0;
        end else begin
            asserted <= ~int_line_n;
        end
    end
endmodule

// file: testbench/intr_route_tb_top.sv
// register level testbench for the interrupt router
`timescale 1ns/1ps
`include "intr_route_map.vh"
module intr_route_tb_top;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [22:0] src_event = 23'h00_0000;
    logic [22:0] src_async = 23'h00_0000;
    wire pready;
    wire [31:0] prdata;
    wire pslverr;
    wire [3:0] int_line_n;
    wire irq;
    wire [3:0] asserted;
    logic slverr_seen;
    int num_errors = 0;
    int check_count = 0;
    intr_route u_intr_route (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_event(src_event),
        .src_async(src_async), .int_line_n(int_line_n), .irq(irq));
    host_irq_model u_host_irq_model (.sys_clk(sys_clk), .rst_n(rst_n),
        .int_line_n(int_line_n), .asserted(asserted));
    always #20 sys_clk = ~sys_clk;
    task stop_test;
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        q = prdata;
        slverr_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task rdc(input string what, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        check(what, q, e);
    endtask
    task pulse(input logic [22:0] m);
        @(posedge sys_clk);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= 23'h00_0000;
        repeat (3) @(posedge sys_clk);
    endtask
    initial begin
        #400000;
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc("map1 reset", `OFF_LINE_MAP_FIRST, 32'h0000_0000);
        rdc("map2 reset", `OFF_LINE_MAP_SECOND, 32'h0000_0000);
        rdc("clear read", `OFF_INTERRUPT_CLEAR, 32'h0000_0000);
        wr(`OFF_LINE_MAP_FIRST, 32'hFFFF_FFFF);
        rdc("map1 fields", `OFF_LINE_MAP_FIRST, 32'h000F_FFFF);
        wr(`OFF_LINE_MAP_SECOND, 32'hFFFF_FFFF);
        rdc("map2 fields", `OFF_LINE_MAP_SECOND, 32'h0FFF_FFFC);
        // every extra source onto every line, then cleared
        for (int s = 17; s < 23; s++) begin
            for (int v = 0; v < 4; v++) begin
                wr(`OFF_LINE_MAP_SECOND, 32'(v) << (16 + 2 * (s - 17)));
                pulse(23'h00_0001 << s);
                check("line", {28'h0, asserted}, 32'h1 << v);
                wr(`OFF_INTERRUPT_CLEAR, 32'h0000_0000);
                rdc("pending kept", `OFF_PENDING_STATUS, 32'h1 << s);
                wr(`OFF_INTERRUPT_CLEAR, 32'h1 << (30 - s));
                rdc("pending dropped", `OFF_PENDING_STATUS, 32'h0000_0000);
                check("line idle", {28'h0, asserted}, 32'h0000_0000);
            end
        end
        wr(`OFF_LINE_MAP_FIRST, 32'h0000_000A);
        pulse(23'h00_0003);
        check("shared line", {28'h0, asserted}, 32'h0000_0004);
        wr(`OFF_INTERRUPT_CLEAR, 32'h0001_0000);
        rdc("one left", `OFF_PENDING_STATUS, 32'h0000_0002);
        check("shared held", {28'h0, asserted}, 32'h0000_0004);
        wr(`OFF_INTERRUPT_CLEAR, 32'h0002_0000);
        rdc("none left", `OFF_PENDING_STATUS, 32'h0000_0000);
        check("shared idle", {28'h0, asserted}, 32'h0000_0000);
        // a masked source never becomes pending
        wr(`OFF_MASK, 32'h007F_FFFE);
        pulse(23'h00_0001);
        rdc("masked source", `OFF_PENDING_STATUS, 32'h0000_0000);
        wr(`OFF_MASK, 32'h007F_FFFF);
        // first map sources each onto a line, then cleared
        for (int s = 0; s < 10; s++) begin
            wr(`OFF_LINE_MAP_FIRST, 32'(s % 4) << (2 * s));
            pulse(23'h00_0001 << s);
            check("first map line", {28'h0, asserted}, 32'h1 << (s % 4));
            wr(`OFF_INTERRUPT_CLEAR, 32'h1 << (16 + s));
            rdc("first map dropped", `OFF_PENDING_STATUS, 32'h0000_0000);
            check("first map idle", {28'h0, asserted}, 32'h0000_0000);
        end
        wr(`OFF_INTR_MASK, 32'h0000_0002);
        rdc("unmapped read", 12'h020, 32'h0000_0000);
        check("slverr", {31'h0, slverr_seen}, 32'h0000_0001);
        rdc("event status", `OFF_INTR_STATUS, 32'h0000_0002);
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        wr(`OFF_INTR_STATUS, 32'h0000_0002);
        @(posedge sys_clk);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        wr(`OFF_INTERRUPT_CLEAR, 32'h0001_0000);
        rdc("idle clear event", `OFF_INTR_STATUS, 32'h0000_0001);
        wr(`OFF_INTR_MASK, 32'h0000_0000);
        wr(12'h020, 32'h0000_FFFF);
        @(posedge sys_clk);
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        // pin level source through the synchroniser, level1 onto line c
        wr(`OFF_LINE_MAP_SECOND, 32'h0000_0008);
        src_async <= 23'h00_0400;
        repeat (6) @(posedge sys_clk);
        check("async line", {28'h0, asserted}, 32'h0000_0004);
        rdc("async pending", `OFF_PENDING_STATUS, 32'h0000_0400);
        stop_test;
    end
endmodule
